// file: bpm_breakpoint_match.sv
// breakpoint match registers with address, attribute, pc and data comparators
`timescale 1ns/1ps
module bpm_breakpoint_match (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // serial debug port register commands
  input wire logic debugRegWriteCmd,
  input wire logic debugRegReadCmd,
  input wire logic [bpm_pkg::SEL_W-1:0] hostRegSelect,
  input wire logic [bpm_pkg::DATA_W-1:0] hostWriteData,
  output logic [bpm_pkg::DATA_W-1:0] hostReadData,
  output logic hostReadValid,
  // serial debug port memory access
  input wire logic hostMemAccess,
  input wire logic [bpm_pkg::DATA_W-1:0] hostMemAddr,
  input wire logic [bpm_pkg::DATA_W-1:0] hostMemData,
  output logic [1:0] memSpaceType,
  output logic [2:0] memSpaceModifier,
  output logic memAltMaster,
  // supervisor debug-write instruction
  input wire logic debugWriteInstruction,
  input wire logic [bpm_pkg::SEL_W-1:0] cpuRegSelect,
  input wire logic [bpm_pkg::DATA_W-1:0] cpuWriteData,
  // processor local bus
  input wire logic busValid,
  input wire logic [bpm_pkg::DATA_W-1:0] busAddr,
  input wire logic [bpm_pkg::DATA_W-1:0] busData,
  input wire logic busRead,
  input wire logic [1:0] busSize,
  input wire logic [1:0] busType,
  input wire logic [2:0] busMod,
  // program counter
  input wire logic pcValid,
  input wire logic [bpm_pkg::DATA_W-1:0] pcValue,
  // comparator results and lock state
  output logic addrHit,
  output logic pcHit,
  output logic dataHit,
  output logic processorWriteLock
);
  import bpm_pkg::*;

  typedef struct packed {
    logic lock;
    logic [TRIG_W-1:0] trig;
    logic [ATTR_W-1:0] attr;
    logic [DATA_W-1:0] pcBreakValue;
    logic [DATA_W-1:0] pcBreakMask;
    logic [DATA_W-1:0] upperBound;
    logic [DATA_W-1:0] lowerBound;
    logic [DATA_W-1:0] dataBreakValue;
    logic [DATA_W-1:0] dataBreakMask;
    logic addrHit;
    logic pcHit;
    logic dataHit;
    logic [DATA_W-1:0] rdData;
    logic rdValid;
    logic altMaster;
  } bpm_state_t;

  bpm_state_t state_r;
  bpm_state_t state_nxt;

  logic addrHitComb;
  logic pcHitComb;
  logic dataHitComb;
  logic [LANES-1:0] dataLanes;
  logic dataEnable;

  // lane order: bit 3 is data[31:24], bit 0 is data[7:0]
  always_comb begin
    dataLanes = {state_r.trig[TRG_ED_UU], state_r.trig[TRG_ED_UM],
                 state_r.trig[TRG_ED_LM], state_r.trig[TRG_ED_LL]}
      | {{2{state_r.trig[TRG_ED_WU]}}, {2{state_r.trig[TRG_ED_WL]}}}
      | {LANES{state_r.trig[TRG_ED_LW]}};
    dataEnable = |dataLanes;
  end

  bpm_addr_cmp u_addr_cmp (
    .lower(state_r.lowerBound),
    .upper(state_r.upperBound),
    .attr(state_r.attr),
    .outsideEn(state_r.trig[TRG_OUTSIDE_EN]),
    .rangeEn(state_r.trig[TRG_RANGE_EN]),
    .lowEn(state_r.trig[TRG_LOW_EN]),
    .addr(busAddr),
    .busRead(busRead),
    .busSize(busSize),
    .busType(busType),
    .busMod(busMod),
    .hit(addrHitComb)
  );

  bpm_masked_cmp u_pc_cmp (
    .value(state_r.pcBreakValue),
    .mask(state_r.pcBreakMask),
    .enable(state_r.trig[TRG_PC_EN]),
    .invert(state_r.trig[TRG_PC_INVERT]),
    .laneEn(ALL_LANES),
    .sample(pcValue),
    .hit(pcHitComb)
  );

  bpm_masked_cmp u_data_cmp (
    .value(state_r.dataBreakValue),
    .mask(state_r.dataBreakMask),
    .enable(dataEnable),
    .invert(state_r.trig[TRG_DATA_INVERT]),
    .laneEn(dataLanes),
    .sample(busData),
    .hit(dataHitComb)
  );

  // shared write decode for both writers; only the host may touch the lock
  function automatic bpm_state_t applyWrite(input bpm_state_t s, input logic [SEL_W-1:0] sel,
                                            input logic [DATA_W-1:0] d, input logic fromHost);
    bpm_state_t r;
    r = s;
    unique case (sel)
      REG_CONFIG: if (fromHost) r.lock = d[LOCK_BIT];
      REG_ATTR: r.attr = d[ATTR_W-1:0];
      REG_TRIG: r.trig = d[TRIG_W-1:0];
      REG_PC_VALUE: r.pcBreakValue = d;
      REG_PC_MASK: r.pcBreakMask = d;
      REG_UPPER: r.upperBound = d;
      REG_LOWER: r.lowerBound = d;
      REG_DATA_VALUE: r.dataBreakValue = d;
      REG_DATA_MASK: r.dataBreakMask = d;
      default: r = s;
    endcase
    return r;
  endfunction

  // narrow registers read back zero-extended to a full word
  function automatic logic [DATA_W-1:0] readWord(input bpm_state_t s,
                                                 input logic [SEL_W-1:0] sel);
    logic [DATA_W-1:0] w;
    w = ZERO_WORD;
    unique case (sel)
      REG_CONFIG: w[LOCK_BIT] = s.lock;
      REG_ATTR: w[ATTR_W-1:0] = s.attr;
      REG_TRIG: w[TRIG_W-1:0] = s.trig;
      REG_PC_VALUE: w = s.pcBreakValue;
      REG_PC_MASK: w = s.pcBreakMask;
      REG_UPPER: w = s.upperBound;
      REG_LOWER: w = s.lowerBound;
      REG_DATA_VALUE: w = s.dataBreakValue;
      REG_DATA_MASK: w = s.dataBreakMask;
      default: w = ZERO_WORD;
    endcase
    return w;
  endfunction

  always_comb begin
    state_nxt = state_r;
    // a processor write is dropped when the host writes in the same cycle; host wins
    if (debugWriteInstruction && !state_r.lock && !debugRegWriteCmd) begin
      state_nxt = applyWrite(state_r, cpuRegSelect, cpuWriteData, 1'b0);
    end
    if (debugRegWriteCmd) begin
      state_nxt = applyWrite(state_r, hostRegSelect, hostWriteData, 1'b1);
    end
    // shared hardware: a memory command clobbers these two
    if (hostMemAccess) begin
      state_nxt.upperBound = hostMemAddr;
      state_nxt.dataBreakMask = hostMemData;
    end
    state_nxt.rdValid = debugRegReadCmd;
    state_nxt.rdData = debugRegReadCmd ? readWord(state_r, hostRegSelect) : state_r.rdData;
    state_nxt.addrHit = busValid && addrHitComb;
    state_nxt.dataHit = busValid && dataHitComb;
    state_nxt.pcHit = pcValid && pcHitComb;
    state_nxt.altMaster = (state_nxt.attr[TT_HI:TT_LO] == TT_ALT_MASTER);
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_r <= '0;
      state_r.attr <= ATTR_RESET;
      state_r.trig <= TRIG_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign hostReadData = state_r.rdData;
  assign hostReadValid = state_r.rdValid;
  assign memSpaceType = state_r.attr[TT_HI:TT_LO];
  assign memSpaceModifier = state_r.attr[TM_HI:TM_LO];
  assign memAltMaster = state_r.altMaster;
  assign addrHit = state_r.addrHit;
  assign pcHit = state_r.pcHit;
  assign dataHit = state_r.dataHit;
  assign processorWriteLock = state_r.lock;

  property p_lock_blocks_cpu;
    @(posedge sys_clk) disable iff (reset)
    (debugWriteInstruction && state_r.lock && !debugRegWriteCmd && !hostMemAccess)
      |=> $stable(state_r.pcBreakValue) && $stable(state_r.lowerBound) && $stable(state_r.attr);
  endproperty
  a_lock_blocks_cpu: assert property (p_lock_blocks_cpu)
    else $error("locked cpu write landed");

  property p_cpu_write_pc;
    @(posedge sys_clk) disable iff (reset)
    (debugWriteInstruction && !state_r.lock && !debugRegWriteCmd && cpuRegSelect == REG_PC_VALUE)
      |=> state_r.pcBreakValue == $past(cpuWriteData);
  endproperty
  a_cpu_write_pc: assert property (p_cpu_write_pc)
    else $error("cpu pc value write lost");

  property p_mem_clobber;
    @(posedge sys_clk) disable iff (reset)
    hostMemAccess |=> state_r.upperBound == $past(hostMemAddr)
      && state_r.dataBreakMask == $past(hostMemData);
  endproperty
  a_mem_clobber: assert property (p_mem_clobber)
    else $error("memory access did not overwrite");

  property p_host_lock;
    @(posedge sys_clk) disable iff (reset)
    (debugRegWriteCmd && hostRegSelect == REG_CONFIG)
      |=> processorWriteLock == $past(hostWriteData[LOCK_BIT]);
  endproperty
  a_host_lock: assert property (p_host_lock) else $error("host lock write wrong");

  property p_read_word;
    @(posedge sys_clk) disable iff (reset)
    (debugRegReadCmd && hostRegSelect == REG_ATTR)
      |=> hostReadValid && hostReadData == {16'h0000, $past(state_r.attr)};
  endproperty
  a_read_word: assert property (p_read_word) else $error("attribute readback wrong");

  property p_attr_reset;
    @(posedge sys_clk) reset |=> state_r.attr == ATTR_RESET && memSpaceModifier == 3'h5;
  endproperty
  a_attr_reset: assert property (p_attr_reset)
    else $error("attribute reset value wrong");

  property p_addr_disabled;
    @(posedge sys_clk) disable iff (reset)
    (state_r.trig[TRG_OUTSIDE_EN:TRG_LOW_EN] == 3'h0) |=> !addrHit;
  endproperty
  a_addr_disabled: assert property (p_addr_disabled)
    else $error("address hit while disabled");

  property p_range_hit;
    @(posedge sys_clk) disable iff (reset)
    (busValid && state_r.trig[TRG_RANGE_EN] && state_r.attr[RWM_BIT:TMM_LO] == 8'hFF
      && busAddr >= state_r.lowerBound && busAddr <= state_r.upperBound) |=> addrHit;
  endproperty
  a_range_hit: assert property (p_range_hit)
    else $error("inclusive range missed");

  property p_pc_hit;
    @(posedge sys_clk) disable iff (reset)
    (pcValid && state_r.trig[TRG_PC_EN] && !state_r.trig[TRG_PC_INVERT]
      && (((pcValue ^ state_r.pcBreakValue) & ~state_r.pcBreakMask) == ZERO_WORD)) |=> pcHit;
  endproperty
  a_pc_hit: assert property (p_pc_hit) else $error("masked pc match missed");

  property p_data_miss;
    @(posedge sys_clk) disable iff (reset)
    (busValid && state_r.trig[TRG_ED_LW] && !state_r.trig[TRG_DATA_INVERT]
      && (((busData ^ state_r.dataBreakValue) & ~state_r.dataBreakMask) != ZERO_WORD))
      |=> !dataHit;
  endproperty
  a_data_miss: assert property (p_data_miss)
    else $error("data hit on unmasked mismatch");

  // read pulse, remaining write paths, alt master flag and compare modes, each against its own rule
  property p_read_pulse;
    @(posedge sys_clk) disable iff (reset)
    !debugRegReadCmd |=> !hostReadValid;
  endproperty
  a_read_pulse: assert property (p_read_pulse) else $error("read valid without a read");

  property p_cpu_upper;
    @(posedge sys_clk) disable iff (reset)
    (debugWriteInstruction && !state_r.lock && !debugRegWriteCmd && !hostMemAccess
      && cpuRegSelect == REG_UPPER) |=> state_r.upperBound == $past(cpuWriteData);
  endproperty
  a_cpu_upper: assert property (p_cpu_upper) else $error("cpu upper write lost");

  property p_host_mask;
    @(posedge sys_clk) disable iff (reset)
    (debugRegWriteCmd && hostRegSelect == REG_DATA_MASK && !hostMemAccess)
      |=> state_r.dataBreakMask == $past(hostWriteData);
  endproperty
  a_host_mask: assert property (p_host_mask) else $error("host mask write lost");

  property p_alt_master;
    @(posedge sys_clk) disable iff (reset)
    memAltMaster == (memSpaceType == TT_ALT_MASTER);
  endproperty
  a_alt_master: assert property (p_alt_master) else $error("alt master flag wrong");

  property p_outside_hit;
    @(posedge sys_clk) disable iff (reset)
    (busValid && state_r.trig[TRG_OUTSIDE_EN] && state_r.attr[RWM_BIT:TMM_LO] == 8'hFF
      && (busAddr < state_r.lowerBound || busAddr > state_r.upperBound)) |=> addrHit;
  endproperty
  a_outside_hit: assert property (p_outside_hit) else $error("outside range missed");

  property p_low_hit;
    @(posedge sys_clk) disable iff (reset)
    (busValid && state_r.trig[TRG_LOW_EN] && state_r.attr[RWM_BIT:TMM_LO] == 8'hFF
      && busAddr == state_r.lowerBound) |=> addrHit;
  endproperty
  a_low_hit: assert property (p_low_hit) else $error("lower bound address missed");

  property p_attr_miss;
    @(posedge sys_clk) disable iff (reset)
    (state_r.attr[RWM_BIT:TMM_LO] == 8'h00
      && {busRead, busSize, busType, busMod} != state_r.attr[RW_BIT:TM_LO]) |=> !addrHit;
  endproperty
  a_attr_miss: assert property (p_attr_miss) else $error("attribute mismatch hit");

  property p_pc_idle;
    @(posedge sys_clk) disable iff (reset)
    (!pcValid || !state_r.trig[TRG_PC_EN]) |=> !pcHit;
  endproperty
  a_pc_idle: assert property (p_pc_idle) else $error("pc hit while idle");

  property p_data_idle;
    @(posedge sys_clk) disable iff (reset)
    (!busValid || state_r.trig[TRG_ED_LW:TRG_ED_UU] == 7'h00) |=> !dataHit;
  endproperty
  a_data_idle: assert property (p_data_idle) else $error("data hit while idle");
endmodule // bpm_breakpoint_match

// file: bpm_pkg.sv
// constants shared by the breakpoint match register set
package bpm_pkg;
  localparam int SEL_W = 4;
  localparam int DATA_W = 32;
  localparam int ATTR_W = 16;
  localparam int TRIG_W = 16;
  localparam int LANES = 4;
  localparam int LANE_W = 8;

  // debug register numbers
  localparam logic [SEL_W-1:0] REG_CONFIG = 4'h0;
  localparam logic [SEL_W-1:0] REG_ATTR = 4'h6;
  localparam logic [SEL_W-1:0] REG_TRIG = 4'h7;
  localparam logic [SEL_W-1:0] REG_PC_VALUE = 4'h8;
  localparam logic [SEL_W-1:0] REG_PC_MASK = 4'h9;
  localparam logic [SEL_W-1:0] REG_UPPER = 4'hC;
  localparam logic [SEL_W-1:0] REG_LOWER = 4'hD;
  localparam logic [SEL_W-1:0] REG_DATA_VALUE = 4'hE;
  localparam logic [SEL_W-1:0] REG_DATA_MASK = 4'hF;

  // bus attribute match layout
  localparam int RWM_BIT = 15;
  localparam int SZM_HI = 14;
  localparam int SZM_LO = 13;
  localparam int TTM_HI = 12;
  localparam int TTM_LO = 11;
  localparam int TMM_HI = 10;
  localparam int TMM_LO = 8;
  localparam int RW_BIT = 7;
  localparam int SZ_HI = 6;
  localparam int SZ_LO = 5;
  localparam int TT_HI = 4;
  localparam int TT_LO = 3;
  localparam int TM_HI = 2;
  localparam int TM_LO = 0;
  localparam logic [ATTR_W-1:0] ATTR_RESET = 16'h0005;

  // size and transfer type codes
  localparam logic [1:0] SIZE_LONG = 2'h0;
  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [1:0] TT_NORMAL = 2'h0;
  localparam logic [1:0] TT_ALT_MASTER = 2'h1;
  localparam logic [1:0] TT_EMULATOR = 2'h2;
  localparam logic [1:0] TT_ACK = 2'h3;

  // trigger definition, level one half
  localparam int TRG_PC_INVERT = 0;
  localparam int TRG_PC_EN = 1;
  localparam int TRG_LOW_EN = 2;
  localparam int TRG_RANGE_EN = 3;
  localparam int TRG_OUTSIDE_EN = 4;
  localparam int TRG_DATA_INVERT = 5;
  localparam int TRG_ED_UU = 6;
  localparam int TRG_ED_UM = 7;
  localparam int TRG_ED_LM = 8;
  localparam int TRG_ED_LL = 9;
  localparam int TRG_ED_WU = 10;
  localparam int TRG_ED_WL = 11;
  localparam int TRG_ED_LW = 12;
  localparam logic [TRIG_W-1:0] TRIG_RESET = 16'h0000;

  // configuration/status
  localparam int LOCK_BIT = 16;
  localparam logic [LANES-1:0] ALL_LANES = 4'hF;
  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
endpackage

// file: bpm_addr_cmp.sv
// operand address range and bus attribute comparator
`timescale 1ns/1ps
module bpm_addr_cmp (
  // bounds and attributes
  input wire logic [bpm_pkg::DATA_W-1:0] lower,
  input wire logic [bpm_pkg::DATA_W-1:0] upper,
  input wire logic [bpm_pkg::ATTR_W-1:0] attr,
  input wire logic outsideEn,
  input wire logic rangeEn,
  input wire logic lowEn,
  // local bus transfer
  input wire logic [bpm_pkg::DATA_W-1:0] addr,
  input wire logic busRead,
  input wire logic [1:0] busSize,
  input wire logic [1:0] busType,
  input wire logic [2:0] busMod,
  // result
  output logic hit
);
  import bpm_pkg::*;
  logic [7:0] attrDiff;
  logic [7:0] attrMask;
  logic attrOk;
  logic inRange;

  always_comb begin
    attrDiff = attr[RW_BIT:TM_LO] ^ {busRead, busSize, busType, busMod};
    attrMask = attr[RWM_BIT:TMM_LO];
    attrOk = ((attrDiff & ~attrMask) == 8'h00);
    inRange = (addr >= lower) && (addr <= upper);
    hit = attrOk && ((rangeEn && inRange) || (outsideEn && !inRange)
      || (lowEn && (addr == lower)));
  end
endmodule // bpm_addr_cmp

// file: bpm_masked_cmp.sv
// masked pattern comparator with per-byte lane enables and invert
`timescale 1ns/1ps
module bpm_masked_cmp (
  // pattern
  input wire logic [bpm_pkg::DATA_W-1:0] value,
  input wire logic [bpm_pkg::DATA_W-1:0] mask,
  // control
  input wire logic enable,
  input wire logic invert,
  input wire logic [bpm_pkg::LANES-1:0] laneEn,
  // observed word
  input wire logic [bpm_pkg::DATA_W-1:0] sample,
  // result
  output logic hit
);
  import bpm_pkg::*;
  logic [LANES-1:0] laneEq;

  genvar i;
  generate
    for (i = 0; i < LANES; i++) begin : g_lane
      // a one in the mask drops that bit from the compare
      assign laneEq[i] = (((sample[i*LANE_W +: LANE_W] ^ value[i*LANE_W +: LANE_W])
        & ~mask[i*LANE_W +: LANE_W]) == 8'h00);
    end
  endgenerate

  assign hit = enable && ((&(laneEq | ~laneEn)) ^ invert);
endmodule // bpm_masked_cmp

// file: bpm_host_model.sv
// model of the external development system on the serial debug port
`timescale 1ns/1ps
module bpm_host_model
  import bpm_pkg::*;
(
  // clock
  input wire logic sys_clk,
  // register commands
  output logic debugRegWriteCmd,
  output logic debugRegReadCmd,
  output logic [bpm_pkg::SEL_W-1:0] hostRegSelect,
  output logic [bpm_pkg::DATA_W-1:0] hostWriteData,
  input wire logic [bpm_pkg::DATA_W-1:0] hostReadData,
  input wire logic hostReadValid,
  // memory command
  output logic hostMemAccess,
  output logic [bpm_pkg::DATA_W-1:0] hostMemAddr,
  output logic [bpm_pkg::DATA_W-1:0] hostMemData
);
  initial begin
    debugRegWriteCmd = 1'b0;
    debugRegReadCmd = 1'b0;
    hostMemAccess = 1'b0;
    hostRegSelect = 4'h0;
    hostWriteData = 32'h0;
    hostMemAddr = 32'h0;
    hostMemData = 32'h0;
  end

  // released fields flip so a late sample never sees a stale value
  task automatic write_reg(input logic [SEL_W-1:0] sel, input logic [DATA_W-1:0] d);
    @(negedge sys_clk);
    debugRegWriteCmd = 1'b1;
    hostRegSelect = sel;
    hostWriteData = d;
    @(negedge sys_clk);
    debugRegWriteCmd = 1'b0;
    hostRegSelect = ~sel;
    hostWriteData = ~d;
  endtask

  task automatic read_reg(input logic [SEL_W-1:0] sel, output logic [DATA_W-1:0] d,
                          output logic v, output logic late);
    @(negedge sys_clk);
    debugRegReadCmd = 1'b1;
    hostRegSelect = sel;
    @(negedge sys_clk);
    debugRegReadCmd = 1'b0;
    hostRegSelect = ~sel;
    d = hostReadData;
    v = hostReadValid;
    @(negedge sys_clk);
    late = hostReadValid;
  endtask

  // callers never overlap this with a processor debug write
  task automatic mem_access(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge sys_clk);
    hostMemAccess = 1'b1;
    hostMemAddr = a;
    hostMemData = d;
    @(negedge sys_clk);
    hostMemAccess = 1'b0;
    hostMemAddr = ~a;
    hostMemData = ~d;
  endtask
endmodule // bpm_host_model

// file: bpm_breakpoint_match_test.sv
// self-checking bench for the breakpoint match register set
`timescale 1ns/1ps
module bpm_breakpoint_match_test;
  import bpm_pkg::*;
  typedef struct packed {
    logic [15:0] trig;
    logic [15:0] attr;
    logic [31:0] addr;
    logic [7:0] bat;
    logic [31:0] pc;
    logic [31:0] dat;
    logic [2:0] hits;
  } bpm_row_t;

  logic sys_clk, reset, debugWriteInstruction, busValid, busRead, pcValid;
  logic debugRegWriteCmd, debugRegReadCmd, hostReadValid, hostMemAccess;
  logic memAltMaster, addrHit, pcHit, dataHit, processorWriteLock, v, late;
  logic [SEL_W-1:0] hostRegSelect, cpuRegSelect;
  logic [DATA_W-1:0] hostWriteData, hostReadData, hostMemAddr, hostMemData;
  logic [DATA_W-1:0] cpuWriteData, busAddr, busData, pcValue, rd;
  logic [1:0] busSize, busType, memSpaceType;
  logic [2:0] busMod, memSpaceModifier;
  logic [7:0] code;
  int errors, checks;
  bpm_row_t rows[$];

  bpm_breakpoint_match i_bpm_breakpoint_match (.sys_clk(sys_clk), .reset(reset),
    .debugRegWriteCmd(debugRegWriteCmd), .debugRegReadCmd(debugRegReadCmd),
    .hostRegSelect(hostRegSelect), .hostWriteData(hostWriteData),
    .hostReadData(hostReadData), .hostReadValid(hostReadValid),
    .hostMemAccess(hostMemAccess), .hostMemAddr(hostMemAddr), .hostMemData(hostMemData),
    .memSpaceType(memSpaceType), .memSpaceModifier(memSpaceModifier),
    .memAltMaster(memAltMaster), .debugWriteInstruction(debugWriteInstruction),
    .cpuRegSelect(cpuRegSelect), .cpuWriteData(cpuWriteData), .busValid(busValid),
    .busAddr(busAddr), .busData(busData), .busRead(busRead), .busSize(busSize),
    .busType(busType), .busMod(busMod), .pcValid(pcValid), .pcValue(pcValue),
    .addrHit(addrHit), .pcHit(pcHit), .dataHit(dataHit),
    .processorWriteLock(processorWriteLock));

  bpm_host_model i_bpm_host_model (.sys_clk(sys_clk), .debugRegWriteCmd(debugRegWriteCmd),
    .debugRegReadCmd(debugRegReadCmd), .hostRegSelect(hostRegSelect),
    .hostWriteData(hostWriteData), .hostReadData(hostReadData),
    .hostReadValid(hostReadValid), .hostMemAccess(hostMemAccess),
    .hostMemAddr(hostMemAddr), .hostMemData(hostMemData));

  task automatic check(input logic [31:0] seen, input logic [31:0] expd);
    checks++;
    if (seen !== expd) begin
      errors++;
      $display("MISMATCH at %0t ns: seen %h expected %h", $time, seen, expd);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic cpu_write(input logic [3:0] sel, input logic [31:0] d);
    @(negedge sys_clk);
    debugWriteInstruction = 1'b1;
    cpuRegSelect = sel;
    cpuWriteData = d;
    @(negedge sys_clk);
    debugWriteInstruction = 1'b0;
    cpuWriteData = ~d;
  endtask

  task automatic probe(input logic [31:0] a, input logic [7:0] b, input logic [31:0] p,
                       input logic [31:0] dt, input logic [2:0] e);
    @(negedge sys_clk);
    busValid = 1'b1;
    pcValid = 1'b1;
    {busRead, busSize, busType, busMod} = b;
    busAddr = a;
    busData = dt;
    pcValue = p;
    @(negedge sys_clk);
    busValid = 1'b0;
    pcValid = 1'b0;
    check({29'h0, addrHit, pcHit, dataHit}, {29'h0, e});
  endtask

  task automatic read_check(input logic [3:0] sel, input logic [31:0] e);
    i_bpm_host_model.read_reg(sel, rd, v, late);
    check(rd, e);
    check({31'h0, v}, 32'h1);
    check({31'h0, late}, 32'h0);
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // the whole sequence needs well under a tenth of this span
  initial begin
    #100000;
    errors++;
    print_verdict();
  end

  initial begin
    reset = 1'b1;
    debugWriteInstruction = 1'b0;
    cpuRegSelect = 4'h0;
    cpuWriteData = 32'h0;
    busValid = 1'b0;
    pcValid = 1'b0;
    {busRead, busSize, busType, busMod} = 8'h0;
    busAddr = 32'h0;
    busData = 32'h0;
    pcValue = 32'h0;
    rows.push_back('{16'h100A, 16'hFF05, 32'h1000, 8'h05, 32'h40AB, 32'h123456FF, 3'h7});
    rows.push_back('{16'h100A, 16'hFF05, 32'h2000, 8'h05, 32'h4100, 32'h12345778, 3'h4});
    rows.push_back('{16'h0008, 16'hFF05, 32'h2001, 8'h05, 32'h40AB, 32'h12345678, 3'h0});
    rows.push_back('{16'h0008, 16'hFF05, 32'h0FFF, 8'h05, 32'h0, 32'h0, 3'h0});
    rows.push_back('{16'h0010, 16'hFF05, 32'h2001, 8'h05, 32'h0, 32'h0, 3'h4});
    rows.push_back('{16'h0010, 16'hFF05, 32'h1800, 8'h05, 32'h0, 32'h0, 3'h0});
    rows.push_back('{16'h0004, 16'hFF05, 32'h1000, 8'h05, 32'h0, 32'h0, 3'h4});
    rows.push_back('{16'h0004, 16'hFF05, 32'h1004, 8'h05, 32'h0, 32'h0, 3'h0});
    rows.push_back('{16'h0008, 16'h0005, 32'h1800, 8'h85, 32'h0, 32'h0, 3'h0});
    rows.push_back('{16'h0008, 16'h8005, 32'h1800, 8'h85, 32'h0, 32'h0, 3'h4});
    rows.push_back('{16'h0008, 16'h7F05, 32'h1800, 8'h65, 32'h0, 32'h0, 3'h4});
    rows.push_back('{16'h0003, 16'hFF05, 32'h0, 8'h05, 32'h4100, 32'h0, 3'h2});
    rows.push_back('{16'h0003, 16'hFF05, 32'h0, 8'h05, 32'h40AB, 32'h0, 3'h0});
    rows.push_back('{16'h1020, 16'hFF05, 32'h0, 8'h05, 32'h0, 32'h12345778, 3'h1});
    rows.push_back('{16'h0040, 16'hFF05, 32'h0, 8'h05, 32'h0, 32'h12FFFFFF, 3'h1});
    rows.push_back('{16'h0040, 16'hFF05, 32'h0, 8'h05, 32'h0, 32'h13345678, 3'h0});
    rows.push_back('{16'h0000, 16'hFF05, 32'h1000, 8'h05, 32'h40AB, 32'h12345678, 3'h0});
    repeat (2) @(negedge sys_clk);
    reset = 1'b0;
    i_bpm_host_model.write_reg(REG_LOWER, 32'h0000_1000);
    cpu_write(REG_UPPER, 32'h0000_2000);
    cpu_write(REG_PC_VALUE, 32'h0000_4000);
    i_bpm_host_model.write_reg(REG_PC_MASK, 32'h0000_00FF);
    cpu_write(REG_DATA_VALUE, 32'h1234_5678);
    i_bpm_host_model.write_reg(REG_DATA_MASK, 32'h0000_00FF);
    foreach (rows[i]) begin
      i_bpm_host_model.write_reg(REG_TRIG, {16'h0, rows[i].trig});
      cpu_write(REG_ATTR, {16'h0, rows[i].attr});
      probe(rows[i].addr, rows[i].bat, rows[i].pc, rows[i].dat, rows[i].hits);
    end
    // every size, type and modifier code, matched exactly and then missed by one
    i_bpm_host_model.write_reg(REG_TRIG, 32'h0000_0008);
    for (int i = 0; i < 128; i++) begin
      code = 8'(i);
      cpu_write(REG_ATTR, {24'h0, code});
      probe(32'h1800, code, ZERO_WORD, ZERO_WORD, 3'h4);
      probe(32'h1800, {1'b0, code[6:0] + 7'h01}, ZERO_WORD, ZERO_WORD, 3'h0);
    end
    i_bpm_host_model.write_reg(REG_ATTR, 32'hFFFF_1234);
    read_check(REG_ATTR, 32'h0000_1234);
    read_check(4'hA, ZERO_WORD);
    i_bpm_host_model.write_reg(REG_ATTR, 32'h0000_000D);
    @(negedge sys_clk);
    check({26'h0, memAltMaster, memSpaceType, memSpaceModifier}, 32'h2D);
    i_bpm_host_model.write_reg(REG_ATTR, 32'h0000_0016);
    @(negedge sys_clk);
    check({26'h0, memAltMaster, memSpaceType, memSpaceModifier}, 32'h16);
    i_bpm_host_model.write_reg(REG_CONFIG, 32'h0001_0000);
    @(negedge sys_clk);
    check({31'h0, processorWriteLock}, 32'h1);
    cpu_write(REG_PC_VALUE, 32'hDEAD_BEEF);
    read_check(REG_PC_VALUE, 32'h0000_4000);
    i_bpm_host_model.write_reg(REG_CONFIG, ZERO_WORD);
    @(negedge sys_clk);
    check({31'h0, processorWriteLock}, 32'h0);
    cpu_write(REG_PC_VALUE, 32'hCAFE_0000);
    read_check(REG_PC_VALUE, 32'hCAFE_0000);
    i_bpm_host_model.mem_access(32'h0000_3000, 32'h0F0F_0F0F);
    read_check(REG_UPPER, 32'h0000_3000);
    read_check(REG_DATA_MASK, 32'h0F0F_0F0F);
    read_check(REG_LOWER, 32'h0000_1000);
    @(negedge sys_clk);
    reset = 1'b1;
    repeat (2) @(negedge sys_clk);
    reset = 1'b0;
    check({26'h0, memAltMaster, memSpaceType, memSpaceModifier}, 32'h05);
    check({28'h0, addrHit, pcHit, dataHit, processorWriteLock}, 32'h0);
    read_check(REG_ATTR, 32'h0000_0005);
    read_check(REG_TRIG, ZERO_WORD);
    print_verdict();
  end
endmodule // bpm_breakpoint_match_test
